// *** bench/pdtat_checker.sv ***
// assertions on the register bus, gate and trigger ports
`default_nettype none
module pdtat_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // state and levels
  input wire logic pwm_output_enable,
  input wire logic protection_active_flag,
  input wire logic overvoltage_port_level,
  input wire logic overvoltage_adc_level,
  // gates and triggers
  input wire logic [2:0] gate_upper,
  input wire logic [2:0] gate_lower,
  input wire logic [5:0] adc_start_trigger
);
  logic [2:0] ctl;
  wire setup = psel && !penable;
  wire lvl = ctl[2] ? overvoltage_adc_level : overvoltage_port_level;
  wire [2:0] on_u = gate_upper ^ {3{~ctl[0]}};
  wire [2:0] on_l = gate_lower ^ {3{~ctl[1]}};
  // shadow of polarity and level source bits
  always @(posedge pclk or negedge presetn)
    if (!presetn) ctl <= 3'h3;
    else if (psel && penable && pready && pwrite && paddr == 12'h00C) ctl <= pwdata[2:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_next: assert property (setup |=> pready ##1 !pready)
    else $error("no ready after setup");
  a_unmapped_err: assert property (setup && paddr > 12'h00C |=> pslverr)
    else $error("no error on unmapped address");
  a_status_bits: assert property (setup && !pwrite && paddr == 12'h000
    |=> prdata == {30'h0, $past(lvl), $past(protection_active_flag)})
    else $error("status read wrong");
  a_trig_enabled: assert property (adc_start_trigger != 0 |-> $past(pwm_output_enable))
    else $error("trigger while disabled");
  a_trig_pulse: assert property (adc_start_trigger != 0 |=> adc_start_trigger == 0)
    else $error("trigger longer than one cycle");
  a_one_route: assert property ($onehot0(adc_start_trigger))
    else $error("trigger on several ports");
  a_no_overlap: assert property (ctl == $past(ctl) |-> (on_u & on_l) == 3'h0)
    else $error("upper and lower on together");
  a_off_disabled: assert property (!$past(pwm_output_enable) && ctl == $past(ctl)
    |-> (on_u | on_l) == 3'h0)
    else $error("gate on while disabled");
  c_trigger: cover property (adc_start_trigger != 0);
  c_status: cover property (setup && paddr == 12'h000);
  c_swap: cover property (on_l[0] ##1 on_u[0]);
endmodule // pdtat_checker
bind pdtat_top pdtat_checker i_pdtat_checker (.*);
`default_nettype wire

// *** bench/pdtat_pwm_model.sv ***
// pwm counter source standing in for the carrier generator
`default_nettype none
module pdtat_pwm_model #(parameter int P = 20) (
  // clock, reset and mode
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic edge_m,
  // counter state
  output logic [15:0] cnt,
  output logic up
);
  timeunit 1ns;
  timeprecision 1ps;
  // held at zero while stopped so the first pwm cycle starts clean
  always @(posedge pclk or negedge presetn) begin
    if (!presetn || !run) begin
      cnt <= 16'h0000;
      up <= 1'b1;
    end else if (edge_m) begin
      cnt <= (cnt == P - 1) ? 16'h0000 : cnt + 16'h0001;
      up <= 1'b1;
    end else begin
      cnt <= up ? cnt + 16'h0001 : cnt - 16'h0001;
      up <= up ? (cnt + 1 < P) : (cnt == 16'h0001);
    end
  end
endmodule // pdtat_pwm_model
`default_nettype wire

// *** bench/tb.sv ***
// self-checking bench: registers, polarity, dead time and adc triggers
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 20;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, en = 0, edge_m = 0;
  logic flag = 0, lp = 0, la = 0, pready, pslverr, up;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, d, q;
  logic [2:0] cmd = 0, sec = 0, gu, gl;
  logic [15:0] cnt;
  logic [5:0] trig;
  int err_count = 0, total_checks = 0, seed = 68887, cyc = 0, i, n, c, b, r, s;
  always #2.5 pclk = ~pclk;
  pdtat_pwm_model #(.P(P)) i_pdtat_pwm_model (.pclk, .presetn, .run(en), .edge_m, .cnt, .up);
  pdtat_top i_pdtat_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pwm_output_enable(en), .pwm_counter(cnt),
    .pwm_period(16'(P)), .count_up(up), .edge_aligned(edge_m), .phase_upper_cmd(cmd),
    .protection_active_flag(flag), .overvoltage_port_level(lp), .overvoltage_adc_level(la),
    .engine_sector(sec), .gate_upper(gu), .gate_lower(gl), .adc_start_trigger(trig));
  task automatic chk(string t, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", t, e, g);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] wd);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(string t, logic [11:0] a, logic [31:0] e);
    apb(0, a, 0);
    chk(t, e, q);
  endtask
  function automatic int exp_trig(int mode, logic em, int cv);
    return ((!em && mode == 2) ? 2 : 1) * (cv == 1 ? 3 : 4);
  endfunction
  task automatic results;
    if (err_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      results();
    end
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    rd("ctrl", 12'h00C, 32'h0000_0003);
    rd("cmp", 12'h008, 32'h0000_0000);
    rd("unmapped", 12'h010, 32'h0000_0000);
    repeat (6) begin
      d = $random(seed);
      flag <= d[0];
      lp <= d[1];
      la <= d[2];
      apb(1, 12'h00C, {29'h0, d[3], 2'b11});
      apb(1, 12'h000, d);
      rd("status", 12'h000, {30'h0, d[3] ? d[2] : d[1], d[0]});
      apb(1, 12'h004, d);
      rd("dead", 12'h004, {24'h0, d[7:0]});
      d[15:0] = 16'(1 + $unsigned(d[15:0]) % (P - 1));
      apb(1, 12'h008, d);
      rd("cmp", 12'h008, {16'h0, d[15:0]});
    end
    for (i = 0; i < 4; i++) begin
      apb(1, 12'h00C, i);
      repeat (2) @(posedge pclk);
      chk("upper", {29'h0, {3{~i[0]}}}, gu);
      chk("lower", {29'h0, {3{~i[1]}}}, gl);
    end
    for (i = 0; i < 2; i++) begin
      @(posedge pclk);
      c = i ? 1 + $unsigned($random(seed)) % 3 : 0;
      en <= 0;
      cmd <= 0;
      apb(1, 12'h004, c);
      en <= 1;
      repeat (150) @(posedge pclk);
      cmd <= 3'b111;
      n = 0;
      @(negedge pclk);
      while (gu[0] !== 1'b1 && n < 200) begin
        n += gl[0] === 1'b0;
        @(negedge pclk);
      end
      chk("dead time", c * 20, n);
    end
    for (i = 0; i < 6; i++) begin
      @(posedge pclk);
      en <= 0;
      edge_m <= i > 2;
      c = i == 0 ? 1 : i == 1 ? P - 1 : 1 + $unsigned($random(seed)) % (P - 1);
      r = $unsigned($random(seed)) % 6;
      s = $unsigned($random(seed)) % 6;
      sec <= s;
      b = i == 0 ? 0 : i % 2 ? s : r;
      apb(1, 12'h008, c);
      apb(1, 12'h00C, 3 | (i % 3) << 3 | (i != 0) << 5 | (i % 2) << 6 | r << 8);
      en <= 1;
      n = 0;
      repeat ((i > 2 ? 4 : 8) * P + 2) begin
        @(negedge pclk);
        n += trig[b];
      end
      chk("triggers", exp_trig(i % 3, i > 2, c), n);
    end
    results();
  end
endmodule // tb
`default_nettype wire

// *** verilog/pdtat_dead_time.v ***
// one phase of the on-delay dead time unit with output polarity
`default_nettype none
`include "pdtat_regs.vh"

module pdtat_dead_time (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // control
  input wire enable,
  input wire upper_cmd,
  input wire [7:0] dead_count,
  input wire pol_upper,
  input wire pol_lower,
  // gate drive
  output reg gate_upper,
  output reg gate_lower
);

  localparam [31:0] STEP_CYC = `PDTAT_DT_STEP_CYC;

  wire [31:0] dt_full = {24'h00_0000, dead_count} * STEP_CYC;
  wire [12:0] dt_cyc = dt_full[12:0];
  wire [1:0] target = enable ? (upper_cmd ? 2'h2 : 2'h1) : 2'h0;

  reg [1:0] last_target;
  reg [1:0] on_state;
  reg [12:0] cnt;
  reg [1:0] next_on;
  reg [12:0] next_cnt;

  // turn-off is immediate, turn-on of the incoming switch waits the dead time
  always @* begin
    next_on = on_state;
    next_cnt = cnt;
    if (target != last_target) begin
      if (dt_cyc == 13'h0000 || target == 2'h0) begin
        next_on = target;
        next_cnt = 13'h0000;
      end else begin
        next_on = 2'h0;
        next_cnt = dt_cyc;
      end
    end else if (cnt != 13'h0000) begin
      next_cnt = cnt - 13'h0001;
      if (cnt == 13'h0001) begin
        next_on = last_target;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_target <= 2'h0;
      on_state <= 2'h0;
      cnt <= 13'h0000;
      gate_upper <= 1'b0;
      gate_lower <= 1'b0;
    end else begin
      last_target <= target;
      on_state <= next_on;
      cnt <= next_cnt;
      gate_upper <= next_on[1] ^ ~pol_upper;
      gate_lower <= next_on[0] ^ ~pol_lower;
    end
  end

endmodule // pdtat_dead_time
`default_nettype wire

// *** verilog/pdtat_regs.vh ***
// register map, field positions, reset values and timing counts
`ifndef PDTAT_REGS_VH
`define PDTAT_REGS_VH

// register byte offsets
`define PDTAT_OFF_STATUS 12'h000
`define PDTAT_OFF_DEADTIME 12'h004
`define PDTAT_OFF_CMP0 12'h008
`define PDTAT_OFF_CTRL 12'h00C

// status fields
`define PDTAT_ST_PROT_BIT 0
`define PDTAT_ST_LEVEL_BIT 1

// control fields
`define PDTAT_CT_POL_UPPER 0
`define PDTAT_CT_POL_LOWER 1
`define PDTAT_CT_SRC_SEL 2
`define PDTAT_CT_TIMING_LO 3
`define PDTAT_CT_TIMING_HI 4
`define PDTAT_CT_SEL_OUT 5
`define PDTAT_CT_ROUTE_SRC 6
`define PDTAT_CT_ROUTE_LO 8
`define PDTAT_CT_ROUTE_HI 10
`define PDTAT_CT_LOAD_SRC 12
`define PDTAT_CTRL_MASK 32'h0000_177F

// reset values
`define PDTAT_DEADTIME_RESET 8'h00
`define PDTAT_CMP_RESET 16'h0000
`define PDTAT_CTRL_RESET 32'h0000_0003

// trigger timing codes
`define PDTAT_TIM_UP 2'h0
`define PDTAT_TIM_DOWN 2'h1
`define PDTAT_TIM_BOTH 2'h2

// number of trigger output ports
`define PDTAT_TRIG_PORTS 6

// dead time step: 100 ns per count, clock 200 MHz
`define PDTAT_DT_STEP_NS 100
`define PDTAT_CLK_MHZ 200
`define PDTAT_DT_STEP_CYC ((`PDTAT_DT_STEP_NS * `PDTAT_CLK_MHZ) / 1000)

`endif

// *** verilog/pdtat_top.v ***
// dead time, output polarity, protection status and adc trigger with apb registers
//
// What this block does
// - status bit 0 shows protection active
// - status bit 1 shows selected source level
// - delay incoming switch turn-on per phase
// - 8-bit dead count, 100 ns steps
// - upper and lower polarity set independently
// - trigger on counter equal to compare
// - trigger on up, down or both
// - edge-aligned mode uses up match only
// - no trigger while output disabled
// - select mode routes trigger by setting or sector
// - compare double-buffered, read returns bus stage
// - compare one skips first pwm cycle
// - polarity one means active high
`default_nettype none
`include "pdtat_regs.vh"

module pdtat_top (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // pwm unit state
  input wire pwm_output_enable,
  input wire [15:0] pwm_counter,
  input wire [15:0] pwm_period,
  input wire count_up,
  input wire edge_aligned,
  input wire [2:0] phase_upper_cmd,
  // protection state
  input wire protection_active_flag,
  input wire overvoltage_port_level,
  input wire overvoltage_adc_level,
  // vector calculation engine
  input wire [2:0] engine_sector,
  // gate drivers
  output wire [2:0] gate_upper,
  output wire [2:0] gate_lower,
  // adc start triggers
  output reg [5:0] adc_start_trigger
);

  // registers
  reg [7:0] dead_count;
  reg [15:0] cmp_bus;
  reg [15:0] cmp_live;
  reg [31:0] ctrl;

  // control fields
  wire pol_upper = ctrl[`PDTAT_CT_POL_UPPER];
  wire pol_lower = ctrl[`PDTAT_CT_POL_LOWER];
  wire src_sel = ctrl[`PDTAT_CT_SRC_SEL];
  wire [1:0] timing = ctrl[`PDTAT_CT_TIMING_HI:`PDTAT_CT_TIMING_LO];
  wire sel_out_mode = ctrl[`PDTAT_CT_SEL_OUT];
  wire route_src = ctrl[`PDTAT_CT_ROUTE_SRC];
  wire [2:0] trigger_route_select = ctrl[`PDTAT_CT_ROUTE_HI:`PDTAT_CT_ROUTE_LO];
  wire buffer_load_source_select = ctrl[`PDTAT_CT_LOAD_SRC];

  // apb decode
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pready & pwrite;

  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `PDTAT_OFF_STATUS) || (a == `PDTAT_OFF_DEADTIME) ||
               (a == `PDTAT_OFF_CMP0) || (a == `PDTAT_OFF_CTRL);
    end
  endfunction

  wire level_sel = src_sel ? overvoltage_adc_level : overvoltage_port_level;

  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h0000_0000;
    case (paddr)
      `PDTAT_OFF_STATUS: begin
        next_rdata[`PDTAT_ST_PROT_BIT] = protection_active_flag;
        next_rdata[`PDTAT_ST_LEVEL_BIT] = level_sel;
      end
      `PDTAT_OFF_DEADTIME: begin
        next_rdata[7:0] = dead_count;
      end
      `PDTAT_OFF_CMP0: begin
        next_rdata[15:0] = cmp_bus;
      end
      `PDTAT_OFF_CTRL: begin
        next_rdata = ctrl;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // answer is prepared in the setup cycle so the access phase needs no wait
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped(paddr);
      if (setup && !pwrite) begin
        prdata <= next_rdata;
      end
    end
  end

  // register writes; the status word is read-only
  wire wr_dead = wr_en && (paddr == `PDTAT_OFF_DEADTIME);
  wire wr_cmp = wr_en && (paddr == `PDTAT_OFF_CMP0);
  wire wr_ctrl = wr_en && (paddr == `PDTAT_OFF_CTRL);

  // software leaves the dead count alone while the outputs run
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dead_count <= `PDTAT_DEADTIME_RESET;
    end else if (wr_dead) begin
      dead_count <= pwdata[7:0];
    end
  end

  // the compare word is taken whole in one access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_bus <= `PDTAT_CMP_RESET;
    end else if (wr_cmp) begin
      cmp_bus <= pwdata[15:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `PDTAT_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= pwdata & `PDTAT_CTRL_MASK;
    end
  end

  // with the load source bit clear, second stage takes the bus stage at each cycle start or while stopped
  wire at_zero = (pwm_counter == 16'h0000);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_live <= `PDTAT_CMP_RESET;
    end else if (!buffer_load_source_select && (!pwm_output_enable || at_zero)) begin
      cmp_live <= cmp_bus;
    end
  end

  // tracks the first pwm cycle after the output enable rises
  localparam [3:0] ST_OFF = 4'b0001;
  localparam [3:0] ST_FIRST = 4'b0010;
  localparam [3:0] ST_LEFT = 4'b0100;
  localparam [3:0] ST_RUN = 4'b1000;

  reg [3:0] cyc_state;
  reg [3:0] next_cyc_state;

  always @* begin
    next_cyc_state = cyc_state;
    case (cyc_state)
      ST_OFF: begin
        if (pwm_output_enable) begin
          next_cyc_state = ST_FIRST;
        end
      end
      ST_FIRST: begin
        if (!pwm_output_enable) begin
          next_cyc_state = ST_OFF;
        end else if (!at_zero) begin
          next_cyc_state = ST_LEFT;
        end
      end
      ST_LEFT: begin
        if (!pwm_output_enable) begin
          next_cyc_state = ST_OFF;
        end else if (at_zero) begin
          next_cyc_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!pwm_output_enable) begin
          next_cyc_state = ST_OFF;
        end
      end
      default: begin
        next_cyc_state = ST_OFF;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_state <= ST_OFF;
    end else begin
      cyc_state <= next_cyc_state;
    end
  end

  // the first cycle ends when the counter comes back to zero
  wire first_cycle = (cyc_state == ST_FIRST) || (cyc_state == ST_LEFT);

  // match detection
  reg dir_ok;
  always @* begin
    if (edge_aligned) begin
      dir_ok = count_up;
    end else begin
      case (timing)
        `PDTAT_TIM_UP: dir_ok = count_up;
        `PDTAT_TIM_DOWN: dir_ok = ~count_up;
        `PDTAT_TIM_BOTH: dir_ok = 1'b1;
        default: dir_ok = count_up;
      endcase
    end
  end

  wire skip_first = first_cycle && (cmp_live == 16'h0001);
  wire hit = pwm_output_enable && (pwm_counter == cmp_live) && dir_ok &&
             !skip_first;
  reg hit_d;
  wire fire = hit & ~hit_d;

  // port index to one-hot trigger word; indexes past the last port drive nothing
  function [5:0] route_onehot;
    input [2:0] idx;
    begin
      case (idx)
        3'h0: route_onehot = 6'h01;
        3'h1: route_onehot = 6'h02;
        3'h2: route_onehot = 6'h04;
        3'h3: route_onehot = 6'h08;
        3'h4: route_onehot = 6'h10;
        3'h5: route_onehot = 6'h20;
        default: route_onehot = 6'h00;
      endcase
    end
  endfunction

  // trigger routing
  wire [2:0] route_idx = route_src ? engine_sector : trigger_route_select;
  reg [5:0] next_trig;
  always @* begin
    next_trig = 6'h00;
    if (fire) begin
      if (!sel_out_mode) begin
        next_trig = route_onehot(3'h0);
      end else begin
        next_trig = route_onehot(route_idx);
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit_d <= 1'b0;
      adc_start_trigger <= 6'h00;
    end else begin
      hit_d <= hit;
      adc_start_trigger <= next_trig;
    end
  end

  // one dead time unit per phase
  genvar ph;
  generate
    for (ph = 0; ph < 3; ph = ph + 1) begin : g_phase
      pdtat_dead_time u_dead (
        .pclk(pclk),
        .presetn(presetn),
        .enable(pwm_output_enable),
        .upper_cmd(phase_upper_cmd[ph]),
        .dead_count(dead_count),
        .pol_upper(pol_upper),
        .pol_lower(pol_lower),
        .gate_upper(gate_upper[ph]),
        .gate_lower(gate_lower[ph])
      );
    end
  endgenerate

endmodule // pdtat_top
`default_nettype wire
